//--- rtl/isd_engine.sv
// Purpose: executes one iso split descriptor held in two apb words
// Contract
// - token bits 43:42, 00 out, 01 in
// - function address in bits 41:35
// - endpoint from bits 34:32 plus bit 31
// - each start split capped at payload cap
// - total byte count bits 17:3, max 1023
// - total count acts as max packet size
// - valid cleared on completion or fatal error
// - bit 46 selects split or high speed
// Assumes: link side accepts one byte per ss_ready cycle
// Notes: fatal_err is a same-clock pulse from the link logic
// Notes: totals above 1023 are clipped; a zero cap moves one byte per split
`timescale 1ns/1ps
`default_nettype none
module isd_engine (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ss_ready,
   input wire logic fatal_err,
   output logic ss_start,
   output logic ss_byte_valid,
   output logic ss_last,
   output logic [1:0] token_type,
   output logic split_mode,
   output logic [6:0] usb_function_addr,
   output logic [3:0] endpoint_number,
   output logic irq
);
   import isd_pkg::*;

   logic [31:0] dw0;
   logic [31:0] next_dw0;
   logic [31:0] dw1;
   logic [31:0] next_dw1;
   isd_state_t state;
   isd_state_t next_state;
   logic [14:0] sent;
   logic [14:0] next_sent;
   logic [10:0] in_split;
   logic [10:0] next_in_split;
   logic [1:0] irq_stat;
   logic [1:0] next_irq_stat;
   logic [1:0] irq_en;
   logic [1:0] next_irq_en;
   logic next_irq;
   logic next_ss_start;
   logic next_ss_valid;
   logic next_ss_last;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [1:0] next_token;
   logic next_split;
   logic [6:0] next_faddr;
   logic [3:0] next_ep;

   // bus strobe and descriptor fields
   logic acc;
   logic wr;
   logic [10:0] cap;
   logic [14:0] total;
   logic [14:0] limit;
   // one-cycle completion events
   logic ev_done;
   logic ev_fatal;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_DW0) || (a == OFS_DW1) || (a == OFS_STAT) || (a == OFS_IRQ_STAT) ||
               (a == OFS_IRQ_EN) || (a == OFS_IRQ_CLR) || (a == OFS_PROGRESS);
   endfunction

   // write strobe aimed at one register
   function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] ofs);
      hit = strobe && (a == ofs);
   endfunction

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign cap = dw0[CAP_HI:CAP_LO];
   assign total = dw0[CNT_HI:CNT_LO];
   // total count doubles as max packet size; iso limit enforced
   assign limit = (total > MAX_ISO_COUNT) ? MAX_ISO_COUNT : total;

   // descriptor execution
   always_comb begin
      next_state = state;
      next_sent = sent;
      next_in_split = in_split;
      next_ss_start = 1'b0;
      next_ss_valid = 1'b0;
      next_ss_last = 1'b0;
      ev_done = 1'b0;
      ev_fatal = 1'b0;
      case (state)
         ISD_IDLE: begin
            // only a valid descriptor is started
            if (dw0[VALID_BIT] && limit != 15'h0) begin
               next_state = ISD_SEND;
               next_sent = 15'h0;
               next_in_split = 11'h0;
               next_ss_start = 1'b1;
            end
         end
         ISD_SEND: begin
            if (fatal_err) begin
               ev_fatal = 1'b1;
               next_state = ISD_DONE;
            end else if (ss_ready) begin
               next_ss_valid = 1'b1;
               next_sent = sent + 15'h1;
               if (sent + 15'h1 >= limit) begin
                  next_ss_last = 1'b1;
                  ev_done = 1'b1;
                  next_state = ISD_DONE;
               end else if (in_split + 11'h1 >= cap) begin
                  next_ss_last = 1'b1;
                  next_in_split = 11'h0;
                  next_ss_start = 1'b1;
               end else begin
                  next_in_split = in_split + 11'h1;
               end
            end
         end
         ISD_DONE: begin
            next_state = ISD_IDLE;
         end
         default: begin
            next_state = ISD_IDLE;
         end
      endcase
   end

   // descriptor low word; hardware clear of valid wins over a write
   always_comb begin
      next_dw0 = dw0;
      if (hit(wr, paddr, OFS_DW0)) begin
         next_dw0 = pwdata;
      end
      if (ev_done || ev_fatal) begin
         next_dw0[VALID_BIT] = 1'b0;
      end
   end

   // descriptor high word; hardware clear of active wins over a write
   always_comb begin
      next_dw1 = dw1;
      if (hit(wr, paddr, OFS_DW1)) begin
         next_dw1 = pwdata;
      end
      if (ev_done || ev_fatal) begin
         next_dw1[ACTIVE_BIT - 32] = 1'b0;
      end
   end

   // interrupt enables
   always_comb begin
      next_irq_en = irq_en;
      if (hit(wr, paddr, OFS_IRQ_EN)) begin
         next_irq_en = pwdata[1:0];
      end
   end

   // interrupt status: set wins over clear
   always_comb begin
      next_irq_stat = irq_stat;
      if (hit(wr, paddr, OFS_IRQ_CLR)) begin
         next_irq_stat = irq_stat & ~pwdata[1:0];
      end
      if (ev_done) begin
         next_irq_stat[IRQ_DONE] = 1'b1;
      end
      if (ev_fatal) begin
         next_irq_stat[IRQ_FATAL] = 1'b1;
      end
      next_irq = |(next_irq_stat & next_irq_en);
   end

   // bus answer: ready, slave error and read data
   always_comb begin
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (psel && !penable) begin
         next_pready = 1'b1;
         next_pslverr = !mapped(paddr);
         case (paddr)
            OFS_DW0: next_prdata = dw0;
            OFS_DW1: next_prdata = dw1;
            OFS_STAT: next_prdata = {30'h0, state};
            OFS_IRQ_STAT: next_prdata = {30'h0, irq_stat};
            OFS_IRQ_EN: next_prdata = {30'h0, irq_en};
            OFS_PROGRESS: next_prdata = {6'h0, in_split, sent};
            default: next_prdata = RESET_WORD;
         endcase
      end
   end

   // decoded fields, one cycle behind the words
   always_comb begin
      next_token = dw1[TOK_HI - 32:TOK_LO - 32];
      next_split = dw1[SPLIT_BIT - 32];
      next_faddr = dw1[ADDR_HI - 32:ADDR_LO - 32];
      next_ep = {dw1[EPH_HI - 32:EPH_LO - 32], dw0[EPL_BIT]};
   end

   // link sequencer registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ISD_IDLE;
         sent <= 15'h0;
         in_split <= 11'h0;
         ss_start <= 1'b0;
         ss_byte_valid <= 1'b0;
         ss_last <= 1'b0;
      end else begin
         state <= next_state;
         sent <= next_sent;
         in_split <= next_in_split;
         ss_start <= next_ss_start;
         ss_byte_valid <= next_ss_valid;
         ss_last <= next_ss_last;
      end
   end

   // descriptor low word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dw0 <= RESET_WORD;
      end else begin
         dw0 <= next_dw0;
      end
   end

   // descriptor high word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dw1 <= RESET_WORD;
      end else begin
         dw1 <= next_dw1;
      end
   end

   // interrupt enables
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_en <= 2'h0;
      end else begin
         irq_en <= next_irq_en;
      end
   end

   // interrupt status and line
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat <= 2'h0;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq <= next_irq;
      end
   end

   // bus answer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= RESET_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // decoded descriptor fields
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         token_type <= TOKEN_OUT;
         split_mode <= 1'b0;
         usb_function_addr <= 7'h0;
         endpoint_number <= 4'h0;
      end else begin
         token_type <= next_token;
         split_mode <= next_split;
         usb_function_addr <= next_faddr;
         endpoint_number <= next_ep;
      end
   end
endmodule
`default_nettype wire

//--- rtl/isd_pkg.sv
// Purpose: constants for the iso split descriptor engine
// Assumes: descriptor words DW0/DW1 form one 64-bit value
// Notes: register offsets are byte addresses on apb
package isd_pkg;
   localparam int unsigned TOK_HI = 43;
   localparam int unsigned TOK_LO = 42;
   localparam int unsigned ADDR_HI = 41;
   localparam int unsigned ADDR_LO = 35;
   localparam int unsigned EPH_HI = 34;
   localparam int unsigned EPH_LO = 32;
   localparam int unsigned EPL_BIT = 31;
   localparam int unsigned CAP_HI = 28;
   localparam int unsigned CAP_LO = 18;
   localparam int unsigned CNT_HI = 17;
   localparam int unsigned CNT_LO = 3;
   localparam int unsigned VALID_BIT = 0;
   localparam int unsigned SPLIT_BIT = 46;
   localparam int unsigned ACTIVE_BIT = 63;
   localparam logic [1:0] TOKEN_OUT = 2'h0;
   localparam logic [1:0] TOKEN_IN = 2'h1;
   localparam logic [14:0] MAX_ISO_COUNT = 15'h3ff;
   localparam logic [7:0] OFS_DW0 = 8'h00;
   localparam logic [7:0] OFS_DW1 = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0] OFS_IRQ_EN = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
   localparam logic [7:0] OFS_PROGRESS = 8'h18;
   localparam int unsigned IRQ_DONE = 0;
   localparam int unsigned IRQ_FATAL = 1;
   localparam logic [31:0] RESET_WORD = 32'h0;
   typedef enum logic [1:0] {ISD_IDLE, ISD_SEND, ISD_DONE} isd_state_t;
endpackage

//--- test/isd_link_sink.sv
// Purpose: link sink; Assumes: byte per ready; Notes: slow stalls
`timescale 1ns/1ps
`default_nettype none
module isd_link_sink (
   input wire logic clk,
   input wire logic rstn,
   input wire logic slow,
   output logic ss_ready
);
   logic [1:0] ph;
   always_ff @(posedge clk or negedge rstn)
      if (!rstn) ph <= 2'h0;
      else ph <= ph + 2'h1;
   assign ss_ready = !slow || ph == 2'h3;
endmodule
`default_nettype wire

//--- test/isd_engine_checker.sv
// Purpose: engine checks; Assumes: apb; Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module isd_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ss_ready,
   input wire logic fatal_err,
   input wire logic ss_byte_valid,
   input wire logic ss_last,
   input wire logic [6:0] usb_function_addr,
   input wire logic irq
);
   logic wr, ev;
   assign wr = psel && penable && pwrite;
   assign ev = wr || ss_last || fatal_err;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("late ready");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("long ready");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("lone error");
   property p_src; $rose(pready) |-> $past(psel && !penable); endproperty
   a_src: assert property (p_src) else $error("stray ready");
   property p_byte; ss_byte_valid |-> $past(ss_ready); endproperty
   a_byte: assert property (p_byte) else $error("stray byte");
   property p_last; ss_last |-> ss_byte_valid; endproperty
   a_last: assert property (p_last) else $error("empty last");
   property p_addr; $changed(usb_function_addr) |-> $past(wr, 2); endproperty
   a_addr: assert property (p_addr) else $error("addr moved");
   property p_irq; $rose(irq) |-> ss_last || $past(ev) || $past(ev, 2); endproperty
   a_irq: assert property (p_irq) else $error("stray irq");
endmodule
bind isd_engine isd_checker isd_checker_inst (.*);
`default_nettype wire

//--- test/tb_iso_split_descriptor_fields.sv
// Purpose: bench; Assumes: 25 MHz; Notes: table, then runs
`timescale 1ns/1ps
`default_nettype none
module tb_iso_split_descriptor_fields;
   import isd_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, fatal_err = 0, slow = 0, er;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ss_ready, ss_start, ss_byte_valid, ss_last, split_mode, irq;
   logic [1:0] token_type;
   logic [6:0] usb_function_addr;
   logic [3:0] endpoint_number;
   int n_fail = 0, checks_done = 0;
   logic [63:0] rows [3] = '{64'h46ad_800c_0038, 64'h03fb_0000_0010, 64'h0408_8000_0000};
   logic [14:0] exps [3] = '{15'h1d5b, 15'h07f6, 15'h1011};
   isd_engine isd_engine_inst (.*);
   isd_link_sink isd_link_sink_inst (.*);
   always #20 clk = ~clk;
   task automatic final_report();
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic hang();
      n_fail++;
      final_report();
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'h1;
      for (k = 0; k < 9 && pready !== 1'h1; k++) @(posedge clk);
      if (pready !== 1'h1) hang();
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic run(input logic [63:0] d, input logic s, f, input int eb, el, input logic [31:0] st);
      int nb = 0, nl = 0, ns = 0;
      slow <= s;
      apb(1'h1, OFS_IRQ_EN, 32'h3);
      apb(1'h1, OFS_DW1, d[63:32]);
      apb(1'h1, OFS_DW0, d[31:0]);
      repeat (f ? 6 : 0) @(posedge clk);
      fatal_err <= f;
      for (int k = 0; irq !== 1'h1; k++) begin
         @(posedge clk) fatal_err <= 1'h0;
         nb += int'(ss_byte_valid === 1'h1);
         nl += int'(ss_last === 1'h1);
         ns += int'(ss_start === 1'h1);
         if (k > 4000) hang();
      end
      if (eb >= 0) chk("counts", {eb[15:0], el[15:0]}, {nb[15:0], nl[15:0]});
      if (eb >= 0) chk("starts", el, ns);
      apb(1'h0, OFS_IRQ_STAT, 32'h0);
      chk("stat", st, rd);
      apb(1'h0, OFS_DW0, 32'h0);
      chk("dw0", d[31:0] & 32'hffff_fffe, rd);
      apb(1'h0, OFS_DW1, 32'h0);
      chk("dw1", d[63:32] & 32'h7fff_ffff, rd);
      apb(1'h1, OFS_IRQ_EN, 32'h0);
      apb(1'h1, OFS_IRQ_CLR, 32'h3);
      chk("irq", 32'h0, 32'(irq));
      $display("run done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      chk("rst", 32'h0, 32'({irq, ss_start, ss_byte_valid, pready}));
      foreach (rows[i]) begin
         apb(1'h1, OFS_DW1, rows[i][63:32]);
         apb(1'h1, OFS_DW0, rows[i][31:0]);
         repeat (2) @(posedge clk);
         chk("decode", 32'(exps[i]), 32'({ss_start, token_type, split_mode, usb_function_addr, endpoint_number}));
      end
      apb(1'h0, 8'h40, 32'h0);
      chk("slverr", 32'h1, 32'(er));
      $display("table done");
      run(64'h8000_0019_0008_0029, 1'h1, 1'h0, 5, 3, 32'h1);
      run(64'h8000_0428_0300_2031, 1'h0, 1'h0, 1023, 6, 32'h1);
      run(64'h8000_0019_02f0_0c81, 1'h1, 1'h1, -1, 0, 32'h2);
      final_report();
   end
endmodule
`default_nettype wire
